//--- core/cfgpin_pkg.sv
// Constants, mode encodings and state type for the configuration pin control block.
// Assumes a 20 MHz system clock; every pin input is synchronised before use.
package cfgpin_pkg;

	// ==========================================================================
	// Clock and synchroniser bank
	localparam int CLK_HZ = 20_000_000;
	localparam int SYNC_W = 12;
	localparam int SYNC_RECONFIG = 0;
	localparam int SYNC_INIT = 1;
	localparam int SYNC_SLAVE_SEL = 2;
	localparam int SYNC_PIN_A = 3;
	localparam int SYNC_PIN_B = 4;
	localparam int SYNC_CONFIG_CLOCK = 5;
	localparam int SYNC_TOE = 6;
	localparam int SYNC_TCK = 7;
	localparam int SYNC_SHIFT_EN = 8;
	localparam int SYNC_SHIFT_DATA = 9;
	localparam int SYNC_MODE_LO = 10;
	localparam int SYNC_MODE_HI = 11;

	// ==========================================================================
	// Configuration modes and sequencing
	localparam logic [1:0] MODE_MASTER_SPI = 2'h0;
	localparam logic [1:0] MODE_SLAVE_SPI = 2'h1;
	localparam int CLEAR_W = 4;
	localparam logic [CLEAR_W-1:0] CLEAR_LAST = 4'h7;
	localparam int DIV_W = 3;
	localparam logic [DIV_W-1:0] CONFIG_CLOCK_HALF_LAST = 3'h3;
	localparam int BIT_CNT_W = 7;
	localparam logic [BIT_CNT_W-1:0] CONFIG_LAST_BIT = 7'h3f;
	localparam int CMD_CNT_W = 4;
	localparam logic [CMD_CNT_W-1:0] CMD_BITS = 4'h8;
	localparam logic [7:0] READ_CMD = 8'h03;
	localparam logic OPEN_DRAIN_LOW = 1'b0;
	localparam int USER_IO_W = 8;

	// ==========================================================================
	// Embedded RAM save timing
	localparam int SAVE_TIME_MS = 1500;
	localparam int SAVE_TIME_MAX_MS = 3000;
	localparam int SAVE_CNT_W = 26;
	localparam int SAVE_CYCLES_DEFAULT = SAVE_TIME_MS * (CLK_HZ / 1000);

	typedef enum logic [1:0] {ST_CLEAR, ST_WAIT_INIT, ST_LOAD, ST_DONE} cfg_state_t;

endpackage

//--- core/test_port_if.sv
// Signals between the configuration core and the test data output stage.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
`default_nettype none
interface test_port_if;
	logic tck_fall;
	logic shift_en;
	logic shift_data;
	logic tdo;
	logic tdo_oe_n;
	modport core (output tck_fall, output shift_en, output shift_data, input tdo, input tdo_oe_n);
	modport stage (input tck_fall, input shift_en, input shift_data, output tdo, output tdo_oe_n);
endinterface
`default_nettype wire

//--- core/tap_output_stage.sv
// Test data output stage: updates the serial output and its enable on test clock falls.
// Assumes the falling edge arrives as a one-cycle pulse from synchronised logic.
`timescale 1ns/10ps
`default_nettype none
module tap_output_stage
(
	input wire logic clk,
	input wire logic sys_rst,
	test_port_if.stage tp
);
	import cfgpin_pkg::*;

	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// ==========================================================================
	// Output register, moved only on a falling test clock
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			tp.tdo <= 1'b0;
			tp.tdo_oe_n <= 1'b1;
		end
		else if (tp.tck_fall)
		begin
			tp.tdo <= tp.shift_data;
			tp.tdo_oe_n <= !tp.shift_en;
		end
	end

	tdo_hold_a: assert property (!tp.tck_fall |=> $stable(tp.tdo) && $stable(tp.tdo_oe_n))
		else $error("test output moved without a falling test clock");
	tdo_shift_a: assert property (tp.tck_fall && tp.shift_en |=>
		!tp.tdo_oe_n && tp.tdo == $past(tp.shift_data))
		else $error("test output did not carry the shifted bit");
endmodule
`default_nettype wire

//--- core/config_pin_control.sv
// Configuration pin control: request, ready and done handshake, mode capture,
// master and slave SPI loading, global I/O tristate and the embedded RAM save timer.
// Assumes pins reach it raw; open-drain pins are split into out and active-low enable.
`timescale 1ns/10ps
`default_nettype none
module config_pin_control
#(
	parameter int SAVE_CYCLES = cfgpin_pkg::SAVE_CYCLES_DEFAULT
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [1:0] cfg_mode_pins,
	input wire logic reconfig_request_n,
	input wire logic init_ready_n_in,
	output logic init_ready_n_out,
	output logic init_ready_n_oe_n,
	input wire logic done_in,
	output logic done_out,
	output logic done_oe_n,
	input wire logic config_clock_in,
	output logic config_clock_out,
	output logic config_clock_oe_n,
	input wire logic spi_data_pin_a_in,
	output logic spi_data_pin_a_out,
	output logic spi_data_pin_a_oe_n,
	input wire logic spi_data_pin_b_in,
	output logic spi_data_pin_b_out,
	output logic spi_data_pin_b_oe_n,
	output logic flash_select_out_n,
	input wire logic slave_select_in_n,
	input wire logic output_tristate_ctl_n,
	input wire logic [cfgpin_pkg::USER_IO_W-1:0] user_io_oe_n_in,
	output logic [cfgpin_pkg::USER_IO_W-1:0] user_io_oe_n,
	input wire logic tck,
	input wire logic test_shift_en,
	input wire logic test_shift_data,
	output logic tdo,
	output logic tdo_oe_n,
	output logic cfg_data,
	output logic cfg_data_valid,
	output logic [1:0] cfg_mode,
	output logic config_done,
	input wire logic ram_save_req,
	output logic ram_save_busy
);
	import cfgpin_pkg::*;

	localparam logic [SAVE_CNT_W-1:0] SAVE_LAST = SAVE_CNT_W'(SAVE_CYCLES - 1);

	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	logic [SYNC_W-1:0] sync_raw;
	logic [SYNC_W-1:0] sync_meta;
	logic [SYNC_W-1:0] sync_q;
	logic init_prev;
	logic config_clock_prev;
	logic tck_prev;
	logic [1:0] mode_q;
	cfg_state_t state;
	logic [CLEAR_W-1:0] clear_cnt;
	logic [DIV_W-1:0] div_cnt;
	logic [CMD_CNT_W-1:0] cmd_cnt;
	logic [7:0] cmd_shift;
	logic [BIT_CNT_W-1:0] bit_cnt;
	logic [SAVE_CNT_W-1:0] save_cnt;
	logic master_load;
	logic slave_load;
	logic master_rise;
	logic master_fall;
	logic slave_rise;
	logic init_rise;
	logic bit_event;
	logic load_entry;
	test_port_if tp();

	// ==========================================================================
	// Pin synchronisers, two flops per input; done is only driven, never read here
	assign sync_raw = {cfg_mode_pins, test_shift_data, test_shift_en, tck, output_tristate_ctl_n,
		config_clock_in, spi_data_pin_b_in, spi_data_pin_a_in, slave_select_in_n,
		init_ready_n_in, reconfig_request_n};

	generate
		for (genvar i = 0; i < SYNC_W; i++)
		begin : g_sync
			always_ff @(posedge clk)
			begin
				sync_meta[i] <= sync_raw[i];
				sync_q[i] <= sync_meta[i];
			end
		end
	endgenerate

	assign mode_q = sync_q[SYNC_MODE_HI:SYNC_MODE_LO];

	// Edge history on the settled stage only
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			init_prev <= 1'b0;
			config_clock_prev <= 1'b0;
			tck_prev <= 1'b0;
		end
		else
		begin
			init_prev <= sync_q[SYNC_INIT];
			config_clock_prev <= sync_q[SYNC_CONFIG_CLOCK];
			tck_prev <= sync_q[SYNC_TCK];
		end
	end

	assign init_rise = sync_q[SYNC_INIT] && !init_prev;
	assign master_load = (state == ST_LOAD) && (cfg_mode == MODE_MASTER_SPI);
	assign slave_load = (state == ST_LOAD) && (cfg_mode != MODE_MASTER_SPI);
	assign load_entry = (state == ST_WAIT_INIT) && init_rise && sync_q[SYNC_RECONFIG];

	// ==========================================================================
	// Configuration sequencer; a request always wins over any other step
	always_ff @(posedge clk)
	begin
		if (sys_rst || !sync_q[SYNC_RECONFIG])
		begin
			state <= ST_CLEAR;
			clear_cnt <= '0;
			init_ready_n_oe_n <= OPEN_DRAIN_LOW;
			done_oe_n <= OPEN_DRAIN_LOW;
			if (sys_rst)
				cfg_mode <= MODE_SLAVE_SPI;
		end
		else
		begin
			case (state)
				ST_CLEAR:
				begin
					if (clear_cnt == CLEAR_LAST)
					begin
						state <= ST_WAIT_INIT;
						init_ready_n_oe_n <= 1'b1;
					end
					else
						clear_cnt <= clear_cnt + 1'b1;
				end
				ST_WAIT_INIT:
				begin
					// An outside driver may stretch init low; capture only on its release
					if (init_rise)
					begin
						cfg_mode <= mode_q;
						state <= ST_LOAD;
					end
				end
				ST_LOAD:
				begin
					// Mode stays frozen here until the next request
					if (bit_event && bit_cnt == CONFIG_LAST_BIT)
					begin
						state <= ST_DONE;
						done_oe_n <= 1'b1;
					end
				end
				default:
				begin
					state <= ST_DONE;
				end
			endcase
		end
	end

	assign init_ready_n_out = OPEN_DRAIN_LOW;
	assign done_out = OPEN_DRAIN_LOW;
	assign config_done = done_oe_n;

	// ==========================================================================
	// Master clock divider; the configuration clock is ours only in master mode
	always_ff @(posedge clk)
	begin
		if (sys_rst || !master_load)
		begin
			div_cnt <= '0;
			config_clock_out <= 1'b0;
		end
		else if (div_cnt == CONFIG_CLOCK_HALF_LAST)
		begin
			div_cnt <= '0;
			config_clock_out <= !config_clock_out;
		end
		else
			div_cnt <= div_cnt + 1'b1;
	end

	assign master_rise = master_load && div_cnt == CONFIG_CLOCK_HALF_LAST && !config_clock_out;
	assign master_fall = master_load && div_cnt == CONFIG_CLOCK_HALF_LAST && config_clock_out;
	// Slave edges come from the host clock as sampled; at 400 ns it gives 8 samples per period
	assign slave_rise = slave_load && sync_q[SYNC_CONFIG_CLOCK] && !config_clock_prev && !sync_q[SYNC_SLAVE_SEL];
	assign bit_event = (master_rise && cmd_cnt == CMD_BITS) || slave_rise;

	// ==========================================================================
	// Read command out, configuration bits in
	always_ff @(posedge clk)
	begin
		if (sys_rst || load_entry)
		begin
			cmd_shift <= READ_CMD;
			cmd_cnt <= '0;
			bit_cnt <= '0;
			cfg_data <= 1'b0;
			cfg_data_valid <= 1'b0;
		end
		else
		begin
			cfg_data_valid <= bit_event;
			if (master_fall)
				cmd_shift <= {cmd_shift[6:0], 1'b0};
			if (master_rise && cmd_cnt != CMD_BITS)
				cmd_cnt <= cmd_cnt + 1'b1;
			if (bit_event)
			begin
				// Master takes data on pin B, slave on pin A
				cfg_data <= master_load ? sync_q[SYNC_PIN_B] : sync_q[SYNC_PIN_A];
				bit_cnt <= bit_cnt + 1'b1;
			end
		end
	end

	// ==========================================================================
	// Pin directions and chip select
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			flash_select_out_n <= 1'b1;
			config_clock_oe_n <= 1'b1;
			spi_data_pin_a_out <= 1'b0;
			spi_data_pin_a_oe_n <= 1'b1;
			spi_data_pin_b_out <= 1'b0;
			spi_data_pin_b_oe_n <= 1'b1;
		end
		else
		begin
			flash_select_out_n <= !master_load;
			config_clock_oe_n <= !master_load;
			spi_data_pin_a_out <= cmd_shift[7];
			spi_data_pin_a_oe_n <= !master_load;
			// Slave echoes the last bit, driving only while selected
			spi_data_pin_b_out <= cfg_data;
			spi_data_pin_b_oe_n <= !(slave_load && !sync_q[SYNC_SLAVE_SEL]);
		end
	end

	// ==========================================================================
	// Global user I/O tristate
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			user_io_oe_n <= '1;
		else if (!sync_q[SYNC_TOE])
			user_io_oe_n <= '1;
		else
			user_io_oe_n <= user_io_oe_n_in;
	end

	// ==========================================================================
	// Embedded RAM save timer, busy for the typical save time
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			save_cnt <= '0;
			ram_save_busy <= 1'b0;
		end
		else if (ram_save_busy)
		begin
			if (save_cnt == SAVE_LAST)
			begin
				ram_save_busy <= 1'b0;
				save_cnt <= '0;
			end
			else
				save_cnt <= save_cnt + 1'b1;
		end
		else if (ram_save_req)
			ram_save_busy <= 1'b1;
	end

	// ==========================================================================
	// Test output stage; the test clock is either parked or free-running
	assign tp.tck_fall = tck_prev && !sync_q[SYNC_TCK];
	assign tp.shift_en = sync_q[SYNC_SHIFT_EN];
	assign tp.shift_data = sync_q[SYNC_SHIFT_DATA];
	assign tdo = tp.tdo;
	assign tdo_oe_n = tp.tdo_oe_n;

	tap_output_stage u_tap_output_stage
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.tp(tp)
	);

	// ==========================================================================
	// Checks
	sequence master_load_s;
		state == ST_LOAD && cfg_mode == MODE_MASTER_SPI;
	endsequence
	sequence slave_load_s;
		state == ST_LOAD && cfg_mode != MODE_MASTER_SPI;
	endsequence

	mode_capture_a: assert property (load_entry |=> state == ST_LOAD && cfg_mode == $past(mode_q))
		else $error("mode not captured at init rise");
	init_release_a: assert property ($rose(init_ready_n_oe_n) |-> $past(clear_cnt) == CLEAR_LAST)
		else $error("init released before clearing finished");
	reconfig_restart_a: assert property (!sync_q[SYNC_RECONFIG] |=> !init_ready_n_oe_n && !done_oe_n)
		else $error("request did not restart configuration");
	done_release_a: assert property ($rose(done_oe_n) |->
		$past(bit_event) && $past(bit_cnt) == CONFIG_LAST_BIT)
		else $error("done released at the wrong bit");
	master_dir_a: assert property (master_load_s ##1 master_load_s |->
		!spi_data_pin_a_oe_n && spi_data_pin_b_oe_n)
		else $error("master pin directions wrong");
	flash_select_a: assert property (master_load_s ##1 master_load_s |->
		!flash_select_out_n && !config_clock_oe_n)
		else $error("flash not selected while loading");
	slave_quiet_a: assert property (slave_load_s and sync_q[SYNC_SLAVE_SEL] |=>
		spi_data_pin_b_oe_n && !cfg_data_valid)
		else $error("slave answered while not selected");
	io_tristate_a: assert property (!sync_q[SYNC_TOE] |=> user_io_oe_n == '1)
		else $error("user I/O not tristated");
	save_time_a: assert property ($fell(ram_save_busy) |-> $past(save_cnt) == SAVE_LAST)
		else $error("save ended early");
	mode_hold_a: assert property (state == ST_LOAD && $past(state) == ST_LOAD |-> $stable(cfg_mode))
		else $error("mode changed during loading");
endmodule
`default_nettype wire

//--- dv/spi_flash_model.sv
// Serial flash model holding a fixed 64-bit image for master loading.
// Assumes mode-0 clocking: samples on rising, launches on falling clock.
`timescale 1ns/10ps
`default_nettype none
module spi_flash_model
#(
	parameter logic [63:0] IMAGE = 64'h0
)
(
	input wire logic sel_n,
	input wire logic sck,
	input wire logic mosi,
	output logic miso,
	output logic [7:0] cmd
);
	int n = 0;
	// ==========================================================================
	// Command capture on the rise, image launch on the fall, one process per variable set
	always @(posedge sck or negedge sck or posedge sel_n)
	begin
		if (sel_n)
		begin
			// Released line must not show a stale level
			n <= 0;
			miso <= (miso === 1'b1) ? 1'b0 : 1'b1;
		end
		else if (sck)
		begin
			if (n < 8)
				cmd <= {cmd[6:0], mosi};
			n <= n + 1;
		end
		else if (n >= 8 && n < 72)
			miso <= IMAGE[71 - n]; // Launch on the fall so the bit settles half a period ahead
	end
endmodule
`default_nettype wire

//--- dv/test_config_pin_control.sv
// Self-checking bench for the configuration pin control block.
// Assumes the flash model on the master side; the bench acts as slave host.
`timescale 1ns/10ps
`default_nettype none
module test_config_pin_control;
	import cfgpin_pkg::*;
	localparam int SAVE_N = 20;
	localparam logic [63:0] IMG_M = 64'hc3a5_0f96_1e2d_7b48;
	localparam logic [63:0] IMG_S = 64'h5a17_e2c4_9d03_b6f8;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [1:0] cfg_mode_pins = 2'h1;
	logic reconfig_request_n = 1'b1;
	logic hold_init = 1'b0;
	logic host_clk = 1'b0;
	logic host_a = 1'b0;
	logic slave_select_in_n = 1'b1;
	logic output_tristate_ctl_n = 1'b1;
	logic [USER_IO_W-1:0] user_io_oe_n_in = 8'h5a;
	logic tck = 1'b0;
	logic test_shift_en = 1'b0;
	logic test_shift_data = 1'b0;
	logic ram_save_req = 1'b0;
	logic init_ready_n_in, init_ready_n_out, init_ready_n_oe_n, done_in, done_out, done_oe_n;
	logic config_clock_in, config_clock_out, config_clock_oe_n, flash_select_out_n;
	logic pin_a_in, pin_a_out, pin_a_oe_n, pin_b_in, pin_b_out, pin_b_oe_n, miso;
	logic tdo, tdo_oe_n, cfg_data, cfg_data_valid, config_done, ram_save_busy;
	logic [1:0] cfg_mode;
	logic [7:0] flash_cmd;
	logic [USER_IO_W-1:0] user_io_oe_n;
	logic [63:0] rx = 64'h0;
	int nrx = 0;
	int n_fail = 0;
	int cmp_count = 0;
	int cycles = 0;

	// ==========================================================================
	// Wires: pull-ups on open drain, shared data and clock pins
	assign init_ready_n_in = !((!init_ready_n_oe_n && !init_ready_n_out) || hold_init);
	assign done_in = done_oe_n ? 1'b1 : done_out;
	assign config_clock_in = config_clock_oe_n ? host_clk : config_clock_out;
	assign pin_a_in = pin_a_oe_n ? host_a : pin_a_out;
	assign pin_b_in = pin_b_oe_n ? miso : pin_b_out;

	config_pin_control #(.SAVE_CYCLES(SAVE_N)) i_config_pin_control (.clk(clk), .sys_rst(sys_rst),
		.cfg_mode_pins(cfg_mode_pins), .reconfig_request_n(reconfig_request_n),
		.init_ready_n_in(init_ready_n_in), .init_ready_n_out(init_ready_n_out),
		.init_ready_n_oe_n(init_ready_n_oe_n), .done_in(done_in), .done_out(done_out),
		.done_oe_n(done_oe_n), .config_clock_in(config_clock_in), .config_clock_out(config_clock_out),
		.config_clock_oe_n(config_clock_oe_n), .spi_data_pin_a_in(pin_a_in), .spi_data_pin_a_out(pin_a_out),
		.spi_data_pin_a_oe_n(pin_a_oe_n), .spi_data_pin_b_in(pin_b_in), .spi_data_pin_b_out(pin_b_out),
		.spi_data_pin_b_oe_n(pin_b_oe_n), .flash_select_out_n(flash_select_out_n),
		.slave_select_in_n(slave_select_in_n), .output_tristate_ctl_n(output_tristate_ctl_n),
		.user_io_oe_n_in(user_io_oe_n_in), .user_io_oe_n(user_io_oe_n), .tck(tck),
		.test_shift_en(test_shift_en), .test_shift_data(test_shift_data), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
		.cfg_data(cfg_data), .cfg_data_valid(cfg_data_valid), .cfg_mode(cfg_mode),
		.config_done(config_done), .ram_save_req(ram_save_req), .ram_save_busy(ram_save_busy));

	spi_flash_model #(.IMAGE(IMG_M)) i_spi_flash_model (.sel_n(flash_select_out_n),
		.sck(config_clock_out), .mosi(pin_a_out), .miso(miso), .cmd(flash_cmd));

	// ==========================================================================
	// Clock, received-bit collector and hang guard
	always #25 clk = ~clk;
	// Collect every delivered bit, MSB first
	always @(posedge clk)
	begin
		if (cfg_data_valid === 1'b1)
		begin
			rx <= {rx[62:0], cfg_data};
			nrx <= nrx + 1;
		end
	end
	// Runs take about 1300 cycles; a hang is cut well beyond that
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			n_fail = n_fail + 1;
			stop_test();
		end
	end

	// ==========================================================================
	// Shared tasks
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Request, hold init low with wrong pins, set pins, then release init
	task automatic restart(input logic [1:0] pins);
		reconfig_request_n = 1'b0;
		hold_init = 1'b1;
		cfg_mode_pins = ~pins;
		cyc(4);
		chk("init held", 64'h0, init_ready_n_oe_n);
		chk("done cleared", 64'h0, config_done);
		reconfig_request_n = 1'b1;
		cyc(12);
		chk("init released", 64'h1, init_ready_n_oe_n);
		cfg_mode_pins = pins;
		cyc(3);
		hold_init = 1'b0;
		cyc(5);
		chk("captured mode", {62'h0, pins}, {62'h0, cfg_mode});
		cfg_mode_pins = ~pins;
	endtask
	task automatic host_bit(input logic b);
		host_a = b;
		cyc(4);
		host_clk = 1'b1;
		cyc(4);
		host_clk = 1'b0;
	endtask

	// ==========================================================================
	// Scenarios
	task automatic master_load();
		int base;
		restart(MODE_MASTER_SPI);
		base = nrx;
		chk("flash select", 64'h0, flash_select_out_n);
		chk("pin a driven", 64'h0, pin_a_oe_n);
		chk("pin b input", 64'h1, pin_b_oe_n);
		chk("clock driven", 64'h0, config_clock_oe_n);
		for (int i = 0; i < 800 && config_done !== 1'b1; i++)
			cyc(1);
		cyc(2);
		chk("read command", {56'h0, READ_CMD}, {56'h0, flash_cmd});
		chk("master image", IMG_M, rx);
		chk("master bits", 64'd64, 64'(nrx - base));
		chk("mode held", 64'h0, {62'h0, cfg_mode});
		chk("done released", 64'h1, done_oe_n);
		chk("select released", 64'h1, flash_select_out_n);
		chk("clock released", 64'h1, config_clock_oe_n);
	endtask
	task automatic slave_load();
		int base;
		restart(MODE_SLAVE_SPI);
		base = nrx;
		for (int i = 0; i < 4; i++)
			host_bit(1'b1);
		chk("deselected bits", 64'h0, 64'(nrx - base));
		chk("pin b idle", 64'h1, pin_b_oe_n);
		chk("pin a input", 64'h1, pin_a_oe_n);
		slave_select_in_n = 1'b0;
		cyc(4);
		chk("pin b driven", 64'h0, pin_b_oe_n);
		for (int i = 63; i >= 0; i--)
			host_bit(IMG_S[i]);
		cyc(6);
		chk("slave image", IMG_S, rx);
		chk("slave bits", 64'd64, 64'(nrx - base));
		chk("echo bit", {63'h0, IMG_S[0]}, {63'h0, pin_b_out});
		chk("slave done", 64'h1, config_done);
		slave_select_in_n = 1'b1;
		host_a = ~host_a;
	endtask
	task automatic tristate_test();
		chk("io follows", 64'h5a, user_io_oe_n);
		output_tristate_ctl_n = 1'b0;
		cyc(4);
		chk("io forced off", 64'hff, user_io_oe_n);
		user_io_oe_n_in = 8'h00;
		cyc(2);
		chk("io still off", 64'hff, user_io_oe_n);
		output_tristate_ctl_n = 1'b1;
		cyc(4);
		chk("io restored", 64'h00, user_io_oe_n);
	endtask
	// Output must hold through the rise and change only after the fall
	task automatic tdo_test(input logic d, input logic en);
		tck = 1'b1;
		test_shift_data = d;
		test_shift_en = en;
		cyc(6);
		chk("tdo before fall", {63'h0, ~d}, {63'h0, tdo});
		tck = 1'b0;
		cyc(5);
		chk("tdo data", {63'h0, d}, {63'h0, tdo});
		chk("tdo enable", {63'h0, !en}, {63'h0, tdo_oe_n});
	endtask
	// A second request mid-save must not stretch the busy time
	task automatic save_test();
		int n;
		n = 0;
		ram_save_req = 1'b1;
		cyc(1);
		ram_save_req = 1'b0;
		for (int i = 0; i < 100 && ram_save_busy === 1'b1; i++)
		begin
			ram_save_req = (i == 5);
			n++;
			cyc(1);
		end
		chk("save cycles", 64'(SAVE_N), 64'(n));
	endtask

	// ==========================================================================
	// Main sequence
	initial
	begin
		cyc(16);
		sys_rst = 1'b0;
		cyc(10);
		chk("init after reset", 64'h1, init_ready_n_oe_n);
		chk("done after reset", 64'h0, config_done);
		master_load();
		$display("master load test finished");
		slave_load();
		$display("slave load test finished");
		tristate_test();
		$display("tristate test finished");
		tdo_test(1'b1, 1'b1);
		tdo_test(1'b0, 1'b0);
		$display("test output finished");
		save_test();
		$display("save timer test finished");
		stop_test();
	end
endmodule
`default_nettype wire
